/* File: verilog/tws_regs.svh */
// Purpose: register offsets, bit positions, status codes and reset values
// Assumes: byte offsets on a 4-bit register address port
// Notes: definitions only
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_OFS_CTRL 4'h0
`define TWS_OFS_STAT 4'h4
`define TWS_OFS_DATA 4'h8
`define TWS_OFS_ADDR 4'hC
`define TWS_CB_FLAG 7
`define TWS_CB_ACKEN 6
`define TWS_CB_STA 5
`define TWS_CB_STO 4
`define TWS_CB_WC 3
`define TWS_CB_EN 2
`define TWS_CB_IE 0
`define TWS_SC_A8 8'hA8
`define TWS_SC_B0 8'hB0
`define TWS_SC_B8 8'hB8
`define TWS_SC_C0 8'hC0
`define TWS_SC_C8 8'hC8
`define TWS_SC_F8 8'hF8
`define TWS_CODE_MASK 8'hF8
`define TWS_PRESC_MASK 8'h03
`define TWS_RST_BYTE 8'h00
`define TWS_RST_DATA 8'hFF
`define TWS_NBITS 4'h8
`define TWS_LAST_TX 4'h7
`endif

/* File: verilog/tws_pkg.sv */
// Purpose: shared types of the two-wire slave transmitter
// Assumes: constants live in tws_regs.svh
// Notes: states are one-hot
package tws_pkg;
	typedef enum logic [5:0] {
		st_idle = 6'h01,
		st_addr = 6'h02,
		st_aack = 6'h04,
		st_tx = 6'h08,
		st_rack = 6'h10,
		st_done = 6'h20
	} tws_state_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} tws_line_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tws_req_t;
endpackage

/* File: verilog/tws_sync.sv */
// Purpose: two-flop synchroniser for the bus pins
// Assumes: inputs are asynchronous to clk_i
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module tws_sync #(parameter int W = 2) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	////////////////////////////////////////////////////////////
	// one synchroniser per pin, idle bus level is high
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				meta_q[i] <= 1'b1;
				q_o[i] <= 1'b1;
			end else begin
				meta_q[i] <= d_i[i];
				q_o[i] <= meta_q[i];
			end
		end
	end
endmodule

/* File: verilog/tws_cond.sv */
// Purpose: clock edge and start/stop detection on synchronised lines
// Assumes: line_i already synchronised to clk_i
// Notes: outputs are one-cycle pulses
`timescale 1ns/1ps
module tws_cond (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire tws_pkg::tws_line_t line_i,
	output logic rise_o,
	output logic fall_o,
	output logic start_o,
	output logic stop_o
);
	import tws_pkg::*;
	tws_line_t prev_q;
	////////////////////////////////////////////////////////////
	// previous line levels
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_q <= '1;
		end else begin
			prev_q <= line_i;
		end
	end
	// edges of clock, data edges while clock high
	assign rise_o = line_i.scl && !prev_q.scl;
	assign fall_o = !line_i.scl && prev_q.scl;
	assign start_o = line_i.scl && prev_q.scl && prev_q.sda && !line_i.sda;
	assign stop_o = line_i.scl && prev_q.scl && !prev_q.sda && line_i.sda;
endmodule

/* File: verilog/tws_slave_tx.sv */
// Purpose: two-wire bus slave transmitter with register port
// Assumes: 50 MHz clk_i samples the bus pins; register strobes from clk_i logic
// Notes: open-drain pins, an enable high pulls the line low
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "tws_regs.svh"
// Behaviour
// - status codes compared with prescaler bits masked
// - respond when top seven address bits match
// - address lsb enables general call response
// - read direction enters transmit, write direction is left unanswered
// - completed bus event sets flag and status
// - own address read acknowledged reports A8
// - lost arbitration then addressed reports B0
// - data byte acknowledged reports B8
// - software loads byte, clears flag, sets ack
// - not-acknowledged data byte reports C0
// - acknowledged final byte reports C8
// - after C0/C8 release becomes not addressed
// - ack enable cleared sends one last byte
// - disconnected slave leaves data line released
// - ack enable zero ignores own address
// - address recognised during sleep, wake requested
// - clock held low through wake until release
// - data register not refilled from bus
// - flag clear reads status F8
module tws_slave_tx (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire tws_pkg::tws_req_t bus_i,
	output logic [7:0] rdata_o,
	input wire tws_pkg::tws_line_t line_i,
	output tws_pkg::tws_line_t line_o,
	output tws_pkg::tws_line_t oe_o,
	input wire logic sleep_i,
	input wire logic arb_lost_i,
	output logic wake_o,
	output logic flag_o,
	output logic start_o
);
	import tws_pkg::*;

	tws_line_t ln_s;
	logic rise_w, fall_w, start_w, stop_w;
	tws_state_t st_q;
	logic flag_q, acken_q, sta_q, sto_q, wc_q, en_q, ie_q;
	logic [7:0] addr_q, data_q, code_q, sh_q;
	logic [1:0] presc_q;
	logic [3:0] cnt_q;
	logic last_q, nack_q, arb_q, busy_q;
	logic wr_ctrl, wr_data, flag_clr, release_w, hit_w, ev_w;
	logic [7:0] ev_code, stat_w;

	////////////////////////////////////////////////////////////
	// pin synchronisers and bus condition detection
	tws_sync #(.W(2)) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i(line_i),
		.q_o(ln_s)
	);

	tws_cond u_cond (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.line_i(ln_s),
		.rise_o(rise_w),
		.fall_o(fall_w),
		.start_o(start_w),
		.stop_o(stop_w)
	);

	////////////////////////////////////////////////////////////
	// register port decode
	assign wr_ctrl = bus_i.wr && (bus_i.addr == `TWS_OFS_CTRL);
	assign wr_data = bus_i.wr && (bus_i.addr == `TWS_OFS_DATA);
	assign flag_clr = wr_ctrl && bus_i.wdata[`TWS_CB_FLAG];
	assign release_w = flag_q && flag_clr; // software hands the bus back

	// address match: own address or enabled general call
	assign hit_w = acken_q &&
		((sh_q[7:1] == addr_q[7:1]) ||
		((sh_q[7:1] == 7'h00) && addr_q[0]));

	// bus events that raise the flag and their codes
	assign ev_w = en_q && fall_w && ((st_q == st_aack) || (st_q == st_rack));
	always_comb begin
		ev_code = `TWS_SC_A8;
		if (st_q == st_aack) begin
			if (arb_q) begin
				ev_code = `TWS_SC_B0;
			end
		end else if (nack_q) begin
			ev_code = `TWS_SC_C0;
		end else if (last_q) begin
			ev_code = `TWS_SC_C8;
		end else begin
			ev_code = `TWS_SC_B8;
		end
	end

	// status view: F8 while no flag, prescaler in low bits
	assign stat_w = (flag_q ? (code_q & `TWS_CODE_MASK) : `TWS_SC_F8)
		| {6'h00, presc_q};

	////////////////////////////////////////////////////////////
	// control bits written by software
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			acken_q <= 1'b0;
			sta_q <= 1'b0;
			sto_q <= 1'b0;
			en_q <= 1'b0;
			ie_q <= 1'b0;
		end else if (wr_ctrl) begin
			acken_q <= bus_i.wdata[`TWS_CB_ACKEN];
			sta_q <= bus_i.wdata[`TWS_CB_STA];
			sto_q <= bus_i.wdata[`TWS_CB_STO];
			en_q <= bus_i.wdata[`TWS_CB_EN];
			ie_q <= bus_i.wdata[`TWS_CB_IE];
		end
	end

	// event flag: the bus event wins over a clearing write
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			flag_q <= 1'b0;
		end else if (ev_w) begin
			flag_q <= 1'b1;
		end else if (flag_clr || !en_q) begin
			flag_q <= 1'b0;
		end
	end

	// status code latched with each event
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			code_q <= `TWS_SC_F8;
		end else if (ev_w) begin
			code_q <= ev_code;
		end
	end

	// prescaler bits, stored only
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			presc_q <= 2'h0;
		end else if (bus_i.wr && (bus_i.addr == `TWS_OFS_STAT)) begin
			presc_q <= bus_i.wdata[1:0];
		end
	end

	// own address register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			addr_q <= `TWS_RST_BYTE;
		end else if (bus_i.wr && (bus_i.addr == `TWS_OFS_ADDR)) begin
			addr_q <= bus_i.wdata;
		end
	end

	// data register: written only while the flag is set, never from the bus
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			data_q <= `TWS_RST_DATA;
			wc_q <= 1'b0;
		end else if (wr_data) begin
			if (flag_q) begin
				data_q <= bus_i.wdata;
				wc_q <= 1'b0;
			end else begin
				wc_q <= 1'b1; // collision, byte dropped
			end
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata_o <= `TWS_RST_BYTE;
		end else if (bus_i.rd) begin
			unique case (bus_i.addr)
				`TWS_OFS_CTRL: rdata_o <= {flag_q, acken_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q};
				`TWS_OFS_STAT: rdata_o <= stat_w;
				`TWS_OFS_DATA: rdata_o <= data_q;
				`TWS_OFS_ADDR: rdata_o <= addr_q;
				default: rdata_o <= `TWS_RST_BYTE;
			endcase
		end else begin
			rdata_o <= `TWS_RST_BYTE;
		end
	end

	////////////////////////////////////////////////////////////
	// arbitration loss marker and bus busy tracking
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			arb_q <= 1'b0;
		end else if (arb_lost_i) begin
			arb_q <= 1'b1;
		end else if (stop_w || (ev_w && (st_q == st_aack))) begin
			arb_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_q <= 1'b0;
		end else if (start_w) begin
			busy_q <= 1'b1;
		end else if (stop_w) begin
			busy_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// transfer sequencer
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_q <= st_idle;
			sh_q <= 8'hFF;
			cnt_q <= 4'h0;
			last_q <= 1'b0;
			nack_q <= 1'b0;
		end else if (!en_q) begin
			st_q <= st_idle;
		end else if (start_w) begin
			st_q <= st_addr;
			cnt_q <= 4'h0;
		end else if (stop_w) begin
			st_q <= st_idle;
		end else begin
			unique case (st_q)
				st_idle: begin
				end
				st_addr: begin
					if (rise_w) begin
						sh_q <= {sh_q[6:0], ln_s.sda};
						cnt_q <= cnt_q + 4'h1;
					end else if (fall_w && (cnt_q == `TWS_NBITS)) begin
						// read direction acknowledged, write or no match goes to st_done
						st_q <= (hit_w && sh_q[0]) ? st_aack : st_done;
					end
				end
				st_aack: begin
					if (fall_w) begin
						st_q <= st_tx;
						cnt_q <= 4'h0;
						nack_q <= 1'b0;
						last_q <= 1'b0;
					end
				end
				st_tx: begin
					if (release_w) begin
						if (nack_q || last_q) begin
							st_q <= st_done;
						end else begin
							sh_q <= data_q;
							last_q <= !bus_i.wdata[`TWS_CB_ACKEN];
							cnt_q <= 4'h0;
						end
					end else if (!flag_q && fall_w) begin
						sh_q <= {sh_q[6:0], 1'b1};
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == `TWS_LAST_TX) begin
							st_q <= st_rack;
						end
					end
				end
				st_rack: begin
					if (rise_w) begin
						nack_q <= ln_s.sda;
					end else if (fall_w) begin
						st_q <= st_tx;
					end
				end
				st_done: begin
					// master clocks ignored until start or stop
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// open-drain drivers
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			oe_o <= '0;
			line_o <= '0;
		end else begin
			line_o <= '0;
			// clock held low from the event until software releases
			oe_o.scl <= en_q && (ev_w || (flag_q && (st_q == st_tx)));
			oe_o.sda <= en_q && ((st_q == st_aack) ||
				((st_q == st_tx) && !flag_q && !sh_q[7]));
		end
	end

	// wake request: address match seen while asleep
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wake_o <= 1'b0;
		end else if (ev_w && (st_q == st_aack) && sleep_i) begin
			wake_o <= 1'b1;
		end else if (!sleep_i) begin
			wake_o <= 1'b0;
		end
	end

	// flag and start request outputs
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			flag_o <= 1'b0;
			start_o <= 1'b0;
		end else begin
			flag_o <= flag_q && ie_q;
			start_o <= en_q && sta_q && !busy_q && (st_q == st_idle || st_q == st_done);
		end
	end

	////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	a_idle_code: assert property (!flag_q |-> (stat_w & `TWS_CODE_MASK) == `TWS_SC_F8)
		else $error("status not F8 while flag clear");

	a_addr_ack_code: assert property ((st_q == st_aack) && fall_w && en_q |=>
		flag_q && (code_q == `TWS_SC_A8 || code_q == `TWS_SC_B0))
		else $error("address ack did not report A8 or B0");

	a_arb_code: assert property ((st_q == st_aack) && fall_w && en_q && arb_q && !start_w |=>
		code_q == `TWS_SC_B0)
		else $error("arbitration loss not reported B0");

	a_nack_code: assert property ((st_q == st_rack) && fall_w && en_q && nack_q |=>
		flag_q && code_q == `TWS_SC_C0)
		else $error("nack not reported C0");

	a_more_code: assert property ((st_q == st_rack) && fall_w && en_q && !nack_q && !last_q |=>
		code_q == `TWS_SC_B8)
		else $error("ack not reported B8");

	a_last_code: assert property ((st_q == st_rack) && fall_w && en_q && !nack_q && last_q |=>
		code_q == `TWS_SC_C8)
		else $error("ack after last byte not reported C8");

	a_stretch_hold: assert property (en_q && flag_q && (st_q == st_tx) && !start_w && !stop_w |=>
		oe_o.scl)
		else $error("clock not stretched while flag set");

	a_done_release: assert property ((st_q == st_done) ##1 (st_q == st_done) |-> !oe_o.sda)
		else $error("data line driven after disconnect");

	a_nomatch_ignore: assert property ((st_q == st_addr) && fall_w && (cnt_q == `TWS_NBITS) && en_q
		&& !acken_q && !start_w && !stop_w |=> st_q == st_done)
		else $error("address answered with ack enable clear");

	a_final_release: assert property ((st_q == st_tx) && release_w && (nack_q || last_q) && en_q
		&& !start_w && !stop_w |=> (st_q == st_done) ##1 !oe_o.sda)
		else $error("not addressed state not entered");
endmodule

/* File: verification/tws_master_model.sv */
// Purpose: bus master that reads bytes from the slave
// Assumes: bench resolves the open-drain wires with pull-ups
// Notes: 160 ns bit period; waits while the slave stretches
`timescale 1ns/1ps
module tws_master_model (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_low_o,
	output logic sda_low_o,
	output logic [7:0] byte_o,
	output logic byte_v_o
);
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
		byte_o = 8'h00;
		byte_v_o = 1'b0;
	end
	// one clock high phase, data sampled late in it
	task automatic pulse(output logic s);
		scl_low_o = 1'b0;
		wait (scl_i === 1'b1);
		#80;
		s = sda_i;
		scl_low_o = 1'b1;
		#80;
	endtask
	task automatic post(input logic [7:0] b);
		byte_o = b;
		byte_v_o = 1'b1;
		#1;
		byte_v_o = 1'b0;
	endtask
	task automatic start_c();
		sda_low_o = 1'b1;
		#80;
		scl_low_o = 1'b1;
		#80;
	endtask
	task automatic stop_c();
		sda_low_o = 1'b1;
		#80;
		scl_low_o = 1'b0;
		wait (scl_i === 1'b1);
		#80;
		sda_low_o = 1'b0;
		#80;
	endtask
	// address byte out, reports the acknowledge bit
	task automatic send(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_low_o = ~b[i];
			pulse(s);
		end
		sda_low_o = 1'b0;
		pulse(s);
		post({7'h00, ~s});
	endtask
	// data byte in, then ack (1) or nack (0)
	task automatic recv(input logic ack);
		logic [7:0] b;
		logic s;
		sda_low_o = 1'b0;
		for (int i = 0; i < 8; i++) begin
			pulse(s);
			b = {b[6:0], s};
		end
		sda_low_o = ack;
		pulse(s);
		sda_low_o = 1'b0;
		post(b);
	endtask
endmodule

/* File: verification/tws_slave_tx_tb.sv */
// Purpose: self-checking bench of the slave transmitter
// Assumes: master model on the wires, software via register port
// Notes: expectations queued by drivers, compared by monitors
`timescale 1ns/1ps
`include "tws_regs.svh"
module tws_slave_tx_tb;
	import tws_pkg::*;
	logic clk_i, reset_i, sleep_i, arb_lost_i, wake_o, flag_o, start_o, scl_low, sda_low, mv;
	logic rd_q = 1'b0;
	tws_req_t bus;
	tws_line_t line, oe;
	logic [7:0] rdata_o, mbyte, own;
	logic [31:0] seed;
	logic [7:0] rq[$];
	logic [7:0] bq[$];
	logic [3:0] ofs[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
	logic [7:0] rv[5] = '{8'h00, 8'hF8, 8'hFF, 8'h00, 8'h00};
	int error_cnt, samples_checked;
	// wired-and of both open-drain parties
	assign line.scl = ~(oe.scl | scl_low);
	assign line.sda = ~(oe.sda | sda_low);
	tws_slave_tx u_tws_slave_tx (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata_o),
		.line_i(line), .line_o(), .oe_o(oe), .sleep_i(sleep_i), .arb_lost_i(arb_lost_i),
		.wake_o(wake_o), .flag_o(flag_o), .start_o(start_o));
	tws_master_model u_tws_master_model (.scl_i(line.scl), .sda_i(line.sda), .scl_low_o(scl_low),
		.sda_low_o(sda_low), .byte_o(mbyte), .byte_v_o(mv));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// read data stands in the cycle after the strobe
	always @(posedge clk_i) begin
		if (rd_q) begin
			cmp(rdata_o, rq.pop_front());
		end
		rd_q <= bus.rd;
	end
	always @(posedge mv) begin
		cmp(mbyte, bq.pop_front());
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk_i);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		rq.push_back(e);
		@(posedge clk_i);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_i);
		bus.rd <= 1'b0;
	endtask
	task automatic mtx(input logic [7:0] b, input logic ack);
		bq.push_back({7'h00, ack});
		u_tws_master_model.send(b);
	endtask
	// software answer to one flag: status, optional byte, control
	task automatic sw_step(input logic [7:0] code, input logic w, input logic ld, input logic [7:0] ctl);
		// flag output still shows the previous event for two edges after a clearing write
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < 4000 && flag_o !== 1'b1; i++) @(posedge clk_i);
		if (flag_o !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t flag never raised", $time);
		end
		cmp({6'h00, wake_o, line.scl}, {6'h00, w, 1'b0});
		rd(`TWS_OFS_STAT, code);
		if (ld) begin
			seed = lfsr(seed);
			bq.push_back(seed[7:0]);
			wr(`TWS_OFS_DATA, seed[7:0]);
		end
		wr(`TWS_OFS_CTRL, ctl);
	endtask
	initial begin
		#200000;
		error_cnt++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		bus = '0;
		sleep_i = 1'b0;
		arb_lost_i = 1'b0;
		reset_i = 1'b1;
		seed = 32'hF8EA;
		error_cnt = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 5; i++) rd(ofs[i], rv[i]);
		wr(`TWS_OFS_STAT, 8'h03);
		rd(`TWS_OFS_STAT, 8'hFB);
		wr(`TWS_OFS_STAT, 8'h00);
		seed = lfsr(seed);
		own = {1'b1, seed[6:1], 1'b1};
		wr(`TWS_OFS_ADDR, own);
		rd(`TWS_OFS_ADDR, own);
		// wrong address, ack disabled, write direction: all unanswered
		for (int i = 0; i < 3; i++) begin
			wr(`TWS_OFS_CTRL, (i == 1) ? 8'h05 : 8'h45);
			u_tws_master_model.start_c();
			mtx((i == 0) ? {own[7:1] ^ 7'h01, 1'b1} : {own[7:1], i == 1}, 1'b0);
			u_tws_master_model.stop_c();
		end
		rd(`TWS_OFS_STAT, 8'hF8);
		// read with acks, last byte acked, then released
		fork
			begin
				u_tws_master_model.start_c();
				mtx({own[7:1], 1'b1}, 1'b1);
				u_tws_master_model.recv(1'b1);
				u_tws_master_model.recv(1'b1);
				bq.push_back(8'hFF);
				u_tws_master_model.recv(1'b0);
				u_tws_master_model.stop_c();
			end
			begin
				sw_step(`TWS_SC_A8, 1'b0, 1'b1, 8'hC5);
				sw_step(`TWS_SC_B8, 1'b0, 1'b1, 8'h85);
				sw_step(`TWS_SC_C8, 1'b0, 1'b0, 8'hC5);
				rd(`TWS_OFS_CTRL, 8'h45);
			end
		join
		// lost arbitration and sleep, master ends with nack
		@(posedge clk_i);
		sleep_i <= 1'b1;
		arb_lost_i <= 1'b1;
		@(posedge clk_i);
		arb_lost_i <= 1'b0;
		fork
			begin
				u_tws_master_model.start_c();
				mtx({own[7:1], 1'b1}, 1'b1);
				u_tws_master_model.recv(1'b0);
				u_tws_master_model.stop_c();
			end
			begin
				sw_step(`TWS_SC_B0, 1'b1, 1'b1, 8'hC5);
				sw_step(`TWS_SC_C0, 1'b1, 1'b0, 8'hC5);
			end
		join
		@(posedge clk_i);
		sleep_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		cmp({6'h00, wake_o, start_o}, 8'h00);
		// start request on a free bus raises the start output
		wr(`TWS_OFS_CTRL, 8'h24);
		repeat (2) @(posedge clk_i);
		cmp({7'h00, start_o}, 8'h01);
		report_and_stop();
	end
endmodule
